/* File: design/spi_host_regs.vh */
// Constants of the serial memory host controller
//
// Notes on behaviour
// - Host sends only defined op-codes
// - Host sets latch before every write
// - Status read: eight clocks, input ignored
// - Status write: eight bits, bits 1,0 ignored
// - Host holds protect pin steady during status write
// - Read: op-code, 16-bit address, top two ignored
// - Read clock at most 25 MHz
// - Write: op-code, address, eight data bits
// - Fast read adds eight dummy bits
// - Other commands clock up to 33 MHz
// - Mode 0: sample rising, change falling
`ifndef SPI_HOST_REGS_VH
`define SPI_HOST_REGS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the command port)
// ----------------------------------------------------------------------
`define R_OPCODE          8'h00
`define R_ADDR            8'h04
`define R_LEN             8'h08
`define R_CTRL            8'h0c
`define R_TXDATA          8'h10
`define R_RXDATA          8'h14
`define R_STATUS          8'h18
`define R_WP              8'h1c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CTRL_START_BIT    0
`define STAT_BUSY_BIT     0
`define STAT_TXFULL_BIT   1
`define STAT_RXFULL_BIT   2
`define STAT_OPERR_BIT    3
`define STAT_WPPIN_BIT    4
`define WP_LEVEL_BIT      0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OPCODE_RST        8'h05
`define ADDR_RST          14'h0000
`define LEN_RST           16'h0001
`define WP_LEVEL_RST      1'b1

// ----------------------------------------------------------------------
// Device op-codes
// ----------------------------------------------------------------------
`define OP_SET_LATCH      8'h06
`define OP_CLEAR_LATCH    8'h04
`define OP_STATUS_READ    8'h05
`define OP_STATUS_WRITE   8'h01
`define OP_READ           8'h03
`define OP_WRITE          8'h02
`define OP_ID_READ        8'h9f
`define OP_FAST_READ      8'h0b

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CORE_CLK_KHZ      25000
`define SCK_READ_MAX_KHZ  25000
`define SCK_FAST_MAX_KHZ  33000
`define MISO_SETTLE_HALF  3
`define CS_GAP_HALVES     8'h02

`endif

/* File: design/pin_sync3.v */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module pin_sync3 #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         clk_i,
   input  wire         rst_n_i,
   // Pin side
   input  wire [W-1:0] d_i,
   // Core side
   output wire [W-1:0] q_o
);

   reg  [W-1:0] s1_r;
   reg  [W-1:0] s2_r;
   reg  [W-1:0] s3_r;
   reg  [W-1:0] hold_r;
   wire [W-1:0] agree;

   // A change only counts once the last two stages agree
   assign agree = ~(s2_r ^ s3_r);
   assign q_o   = (agree & s3_r) | (~agree & hold_r);

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         s1_r   <= {W{1'b1}};
         s2_r   <= {W{1'b1}};
         s3_r   <= {W{1'b1}};
         hold_r <= {W{1'b1}};
      end else begin
         s1_r   <= d_i;
         s2_r   <= s1_r;
         s3_r   <= s2_r;
         hold_r <= q_o;
      end
   end

endmodule // pin_sync3

/* File: design/phase_tick.v */
// Divider that issues one-cycle enables for each serial clock half
`timescale 1ns/100ps
module phase_tick #(
   parameter [7:0] HALF = 8'h03
) (
   // Clock and reset
   input  wire clk_i,
   input  wire rst_n_i,
   // Control
   input  wire run_i,
   // Enable out
   output reg  tick_o
);

   reg [7:0] cnt_r;

   // Restarts whenever run drops, so every phase is a full half
   always @(posedge clk_i) begin
      if (!rst_n_i || !run_i) begin
         cnt_r  <= 8'h00;
         tick_o <= 1'b0;
      end else if (cnt_r == HALF - 8'h01) begin
         cnt_r  <= 8'h00;
         tick_o <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 8'h01;
         tick_o <= 1'b0;
      end
   end

endmodule // phase_tick

/* File: design/spi_mem_host.v */
// Host controller that drives a serial nonvolatile memory
`timescale 1ns/100ps
`include "spi_host_regs.vh"
module spi_mem_host #(
   parameter [7:0] GAP_HALVES = `CS_GAP_HALVES
) (
   // Clock and reset
   input  wire        CORE_CLK_I,
   input  wire        RST_N_I,
   // Command port
   input  wire [7:0]  ADDR_I,
   input  wire [15:0] WDATA_I,
   input  wire        WE_I,
   input  wire        RE_I,
   output reg  [15:0] RDATA_O,
   // Memory pins
   output reg         CS_N_O,
   output reg         SCK_O,
   output reg         MOSI_O,
   input  wire        MISO_I,
   output reg         WP_N_O,
   output reg         HOLD_N_O
);

   // ----------------------------------------------------------------------
   // Serial clock rate
   // ----------------------------------------------------------------------
   // Read limit is the stricter one, so it bounds every command; the settle minimum of 3 cycles per half sets the rate here
   localparam integer MIN_HALF = (`CORE_CLK_KHZ + 2 * `SCK_READ_MAX_KHZ - 1)
                                 / (2 * `SCK_READ_MAX_KHZ);
   localparam integer HALF_I   = (MIN_HALF > `MISO_SETTLE_HALF) ?
                                 MIN_HALF : `MISO_SETTLE_HALF;
   localparam [7:0]   HALF     = HALF_I[7:0];

   // ----------------------------------------------------------------------
   // States
   // ----------------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_WAIT  = 3'h1;
   localparam [2:0] ST_SHIFT = 3'h2;
   localparam [2:0] ST_NEXT  = 3'h3;
   localparam [2:0] ST_GAP   = 3'h4;

   reg  [2:0]  state_r;
   reg  [7:0]  opcode_r;
   reg  [13:0] addr_r;
   reg  [15:0] len_r;
   reg  [7:0]  tx_r;
   reg         tx_full_r;
   reg  [7:0]  rx_r;
   reg         rx_full_r;
   reg         op_err_r;
   reg         wp_level_r;
   reg  [7:0]  sh_r;
   reg  [7:0]  rxs_r;
   reg  [2:0]  bit_r;
   reg         phase_r;
   reg  [2:0]  idx_r;
   reg  [15:0] dleft_r;
   reg         pre_r;
   reg         fin_r;
   reg         cap_r;
   reg  [7:0]  gap_r;
   wire        tick;
   wire        miso;
   wire        run;
   wire        is_wr;
   wire        has_addr;
   wire [2:0]  nhdr;
   wire        start;
   wire        start_ok;
   wire        tx_set;
   wire        rx_clr;
   wire        err_clr;
   reg         tx_take;
   reg         rx_set;
   reg         err_set;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function op_valid;
      input [7:0] op;
      begin
         case (op)
            `OP_SET_LATCH, `OP_CLEAR_LATCH, `OP_STATUS_READ,
            `OP_STATUS_WRITE, `OP_READ, `OP_WRITE,
            `OP_ID_READ, `OP_FAST_READ: op_valid = 1'b1;
            default:                    op_valid = 1'b0;
         endcase
      end
   endfunction

   // Header bytes: op-code, address high, address low, dummy
   function [7:0] hdr_byte;
      input [2:0]  idx;
      input [7:0]  op;
      input [13:0] adr;
      begin
         case (idx)
            3'h0:    hdr_byte = op;
            3'h1:    hdr_byte = {2'b00, adr[13:8]};
            3'h2:    hdr_byte = adr[7:0];
            default: hdr_byte = 8'h00;
         endcase
      end
   endfunction

   wire [7:0]  hdr = hdr_byte(idx_r, opcode_r, addr_r);
   assign is_wr    = (opcode_r == `OP_WRITE) ||
                     (opcode_r == `OP_STATUS_WRITE);
   assign has_addr = (opcode_r == `OP_READ) || (opcode_r == `OP_WRITE) ||
                     (opcode_r == `OP_FAST_READ);
   assign nhdr     = (opcode_r == `OP_FAST_READ) ? 3'h4 :
                     (has_addr ? 3'h3 : 3'h1);
   assign run      = (state_r == ST_SHIFT) || (state_r == ST_GAP);

   // ----------------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------------
   phase_tick #(
      .HALF    (HALF)
   ) u_tick (
      .clk_i   (CORE_CLK_I),
      .rst_n_i (RST_N_I),
      .run_i   (run),
      .tick_o  (tick)
   );

   pin_sync3 #(
      .W       (1)
   ) u_miso (
      .clk_i   (CORE_CLK_I),
      .rst_n_i (RST_N_I),
      .d_i     (MISO_I),
      .q_o     (miso)
   );

   // ----------------------------------------------------------------------
   // Command port
   // ----------------------------------------------------------------------
   assign start    = WE_I && (ADDR_I == `R_CTRL) &&
                     WDATA_I[`CTRL_START_BIT] && (state_r == ST_IDLE);
   assign start_ok = start && op_valid(opcode_r);
   assign tx_set   = WE_I && (ADDR_I == `R_TXDATA);
   assign rx_clr   = RE_I && (ADDR_I == `R_RXDATA);
   assign err_clr  = WE_I && (ADDR_I == `R_STATUS) &&
                     WDATA_I[`STAT_OPERR_BIT];

   // Op-code, address and length stay frozen while a command runs; protect level and transmit data can still be written
   always @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         opcode_r   <= `OPCODE_RST;
         addr_r     <= `ADDR_RST;
         len_r      <= `LEN_RST;
         wp_level_r <= `WP_LEVEL_RST;
         tx_r       <= 8'h00;
      end else if (WE_I) begin
         if (state_r == ST_IDLE) begin
            if (ADDR_I == `R_OPCODE)
               opcode_r <= WDATA_I[7:0];
            if (ADDR_I == `R_ADDR)
               addr_r <= WDATA_I[13:0];
            if (ADDR_I == `R_LEN)
               len_r <= WDATA_I;
         end
         if (ADDR_I == `R_WP)
            wp_level_r <= WDATA_I[`WP_LEVEL_BIT];
         if (tx_set)
            tx_r <= WDATA_I[7:0];
      end
   end

   // Hardware sets win over software clears
   always @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         tx_full_r <= 1'b0;
         rx_full_r <= 1'b0;
         op_err_r  <= 1'b0;
      end else begin
         tx_full_r <= tx_set | (tx_full_r & ~tx_take);
         rx_full_r <= rx_set | (rx_full_r & ~rx_clr);
         op_err_r  <= err_set | (op_err_r & ~err_clr);
      end
   end

   always @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         RDATA_O <= 16'h0000;
      end else if (RE_I) begin
         case (ADDR_I)
            `R_OPCODE: RDATA_O <= {8'h00, opcode_r};
            `R_ADDR:   RDATA_O <= {2'b00, addr_r};
            `R_LEN:    RDATA_O <= len_r;
            `R_TXDATA: RDATA_O <= {8'h00, tx_r};
            `R_RXDATA: RDATA_O <= {8'h00, rx_r};
            `R_STATUS: RDATA_O <= {11'h000, WP_N_O, op_err_r, rx_full_r,
                                   tx_full_r, (state_r != ST_IDLE)};
            `R_WP:     RDATA_O <= {15'h0000, wp_level_r};
            default:   RDATA_O <= 16'h0000;
         endcase
      end else begin
         RDATA_O <= 16'h0000;
      end
   end

   // ----------------------------------------------------------------------
   // Serial engine
   // ----------------------------------------------------------------------
   always @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         state_r  <= ST_IDLE;
         CS_N_O   <= 1'b1;
         SCK_O    <= 1'b0;
         MOSI_O   <= 1'b0;
         WP_N_O   <= `WP_LEVEL_RST;
         HOLD_N_O <= 1'b1;
         sh_r     <= 8'h00;
         rxs_r    <= 8'h00;
         rx_r     <= 8'h00;
         bit_r    <= 3'h0;
         phase_r  <= 1'b0;
         idx_r    <= 3'h0;
         dleft_r  <= 16'h0000;
         pre_r    <= 1'b0;
         fin_r    <= 1'b0;
         cap_r    <= 1'b0;
         gap_r    <= 8'h00;
         tx_take  <= 1'b0;
         rx_set   <= 1'b0;
         err_set  <= 1'b0;
      end else begin
         tx_take  <= 1'b0;
         rx_set   <= 1'b0;
         err_set  <= 1'b0;
         HOLD_N_O <= 1'b1;
         case (state_r)
            ST_IDLE: begin
               // Pin only moves between commands
               if (!start_ok) WP_N_O <= wp_level_r;
               if (start && !start_ok) begin
                  err_set <= 1'b1;
               end else if (start_ok) begin
                  CS_N_O  <= 1'b0;
                  pre_r   <= is_wr;
                  idx_r   <= 3'h0;
                  dleft_r <= len_r;
                  fin_r   <= 1'b0;
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               cap_r <= 1'b0;
               if (pre_r) begin
                  if (idx_r == 3'h0) begin
                     sh_r    <= `OP_SET_LATCH;
                     MOSI_O  <= 1'b0;
                     idx_r   <= 3'h1;
                     state_r <= ST_SHIFT;
                  end else begin
                     CS_N_O  <= 1'b1;
                     pre_r   <= 1'b0;
                     idx_r   <= 3'h0;
                     state_r <= ST_GAP;
                  end
               end else if (idx_r < nhdr) begin
                  sh_r    <= hdr;
                  MOSI_O  <= hdr[7];
                  idx_r   <= idx_r + 3'h1;
                  state_r <= ST_SHIFT;
               end else if (dleft_r != 16'h0000) begin
                  // Stall with the clock low until software keeps up
                  if (is_wr && tx_full_r && !tx_set) begin
                     sh_r    <= tx_r;
                     MOSI_O  <= tx_r[7];
                     tx_take <= 1'b1;
                     dleft_r <= dleft_r - 16'h0001;
                     state_r <= ST_SHIFT;
                  end else if (!is_wr && !rx_full_r && !rx_set) begin
                     sh_r    <= 8'h00;
                     MOSI_O  <= 1'b0;
                     cap_r   <= 1'b1;
                     dleft_r <= dleft_r - 16'h0001;
                     state_r <= ST_SHIFT;
                  end
               end else begin
                  // Rising select ends the command; after a write or status write it also clears the latch
                  CS_N_O  <= 1'b1;
                  fin_r   <= 1'b1;
                  state_r <= ST_GAP;
               end
            end
            ST_SHIFT: begin
               if (tick) begin
                  if (!phase_r) begin
                     SCK_O   <= 1'b1;
                     phase_r <= 1'b1;
                  end else begin
                     rxs_r   <= {rxs_r[6:0], miso};
                     SCK_O   <= 1'b0;
                     phase_r <= 1'b0;
                     if (bit_r == 3'h7) begin
                        bit_r   <= 3'h0;
                        state_r <= ST_NEXT;
                     end else begin
                        bit_r  <= bit_r + 3'h1;
                        sh_r   <= {sh_r[6:0], 1'b0};
                        MOSI_O <= sh_r[6];
                     end
                  end
               end
            end
            ST_NEXT: begin
               if (cap_r) begin
                  rx_r   <= rxs_r;
                  rx_set <= 1'b1;
               end
               cap_r   <= 1'b0;
               state_r <= ST_WAIT;
            end
            ST_GAP: begin
               MOSI_O <= 1'b0;
               if (tick) begin
                  if (gap_r == GAP_HALVES - 8'h01) begin
                     gap_r <= 8'h00;
                     if (fin_r) begin
                        state_r <= ST_IDLE;
                     end else begin
                        CS_N_O  <= 1'b0;
                        state_r <= ST_WAIT;
                     end
                  end else begin
                     gap_r <= gap_r + 8'h01;
                  end
               end
            end
            default: begin
               CS_N_O  <= 1'b1;
               SCK_O   <= 1'b0;
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

endmodule // spi_mem_host

/* File: testbench/spi_mem_host_asserts.sv */
// Pin-level checks on the serial memory host controller
`timescale 1ns/100ps
module spi_mem_host_asserts (
   // Clock and reset
   input wire        CORE_CLK_I,
   input wire        RST_N_I,
   // Command port
   input wire [7:0]  ADDR_I,
   input wire [15:0] WDATA_I,
   input wire        WE_I,
   input wire        RE_I,
   input wire [15:0] RDATA_O,
   // Memory pins
   input wire        CS_N_O,
   input wire        SCK_O,
   input wire        MOSI_O,
   input wire        MISO_I,
   input wire        WP_N_O,
   input wire        HOLD_N_O
);
   // ----------------------------------------------------------------
   // Frame tracking: rising serial edges and the op-code of each frame
   // ----------------------------------------------------------------
   reg [15:0] edges;
   reg [7:0]  sh;
   reg [7:0]  op8;
   reg [7:0]  prev_op;
   reg        sck_d;
   reg        cs_d;
   always @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
         edges   <= 16'h0000;
         sh      <= 8'h00;
         op8     <= 8'h00;
         prev_op <= 8'h00;
         sck_d   <= 1'b0;
         cs_d    <= 1'b1;
      end else begin
         sck_d <= SCK_O;
         cs_d  <= CS_N_O;
         if (CS_N_O) begin
            edges <= 16'h0000;
         end else if (SCK_O && !sck_d) begin
            edges <= edges + 16'h0001;
            sh    <= {sh[6:0], MOSI_O};
            if (edges == 16'h0007) op8 <= {sh[6:0], MOSI_O};
         end
         if (CS_N_O && !cs_d) prev_op <= op8;
      end
   end

   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);

   sck_idle_a: assert property (CS_N_O |-> !SCK_O)
      else $error("serial clock high while deselected");
   mosi_hold_a: assert property (SCK_O |-> $stable(MOSI_O))
      else $error("data out changed while serial clock high");
   sck_high_a: assert property ($rose(SCK_O) |-> SCK_O[*3] ##1 !SCK_O)
      else $error("serial clock high half not three cycles");
   sck_low_a: assert property ($fell(SCK_O) |-> !SCK_O[*3])
      else $error("serial clock low half too short");
   wp_hold_a: assert property (!CS_N_O |-> $stable(WP_N_O))
      else $error("protect pin moved inside a frame");
   frame_bytes_a: assert property ($rose(CS_N_O) |->
      edges != 16'h0000 && edges[2:0] == 3'h0)
      else $error("frame not a whole number of bytes");
   opcode_ok_a: assert property ($rose(CS_N_O) |-> op8 inside
      {8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h02, 8'h9f, 8'h0b})
      else $error("undefined op-code sent");
   latch_first_a: assert property ($rose(CS_N_O) &&
      (op8 == 8'h02 || op8 == 8'h01) |-> prev_op == 8'h06)
      else $error("write frame without set-latch frame before it");
   status_write_cmd_len_a: assert property ($rose(CS_N_O) && op8 == 8'h01
      |-> edges == 16'd16)
      else $error("status write frame length wrong");
   write_len_a: assert property ($rose(CS_N_O) && op8 == 8'h02
      |-> edges >= 16'd32)
      else $error("write frame shorter than header and one byte");
   fast_len_a: assert property ($rose(CS_N_O) && op8 == 8'h0b
      |-> edges >= 16'd40)
      else $error("fast read frame missing dummy or data");
   rdata_idle_a: assert property (!$past(RE_I) |-> RDATA_O == 16'h0000)
      else $error("read data outside the read answer cycle");

   cover property ($rose(CS_N_O) && op8 == 8'h0b);
   cover property ($rose(CS_N_O) && op8 == 8'h01);
   cover property ($rose(CS_N_O) && op8 == 8'h02);
endmodule // spi_mem_host_asserts

bind spi_mem_host spi_mem_host_asserts i_spi_mem_host_asserts (
   .CORE_CLK_I (CORE_CLK_I),
   .RST_N_I    (RST_N_I),
   .ADDR_I     (ADDR_I),
   .WDATA_I    (WDATA_I),
   .WE_I       (WE_I),
   .RE_I       (RE_I),
   .RDATA_O    (RDATA_O),
   .CS_N_O     (CS_N_O),
   .SCK_O      (SCK_O),
   .MOSI_O     (MOSI_O),
   .MISO_I     (MISO_I),
   .WP_N_O     (WP_N_O),
   .HOLD_N_O   (HOLD_N_O)
);

/* File: testbench/spi_mem_model.sv */
// Behavioural model of the serial nonvolatile memory
`timescale 1ns/100ps
module spi_mem_model #(
   parameter [31:0] ID_WORD = 32'h1a2b_3c4d  // Arbitrary identity value
) (
   // Serial pins
   input  wire cs_n_i,
   input  wire sck_i,
   input  wire mosi_i,
   input  wire wp_n_i,
   output reg  miso_o
);
   // ----------------------------------------------------------------
   // Array, status and command decode
   // ----------------------------------------------------------------
   reg [7:0]  mem [0:16383];
   reg [7:0]  stat_r;
   reg [31:0] sh;
   reg [7:0]  op;
   reg [13:0] base;
   reg [13:0] wa;
   reg [13:0] ra;
   integer    bits;
   integer    k;
   integer    i;
   function prot(input [13:0] adr);
      prot = (stat_r[3:2] == 2'b11) | (stat_r[3] & adr[13]) |
             (stat_r[2] & (&adr[13:12]));
   endfunction
   initial begin
      stat_r = 8'h00;
      miso_o = 1'b1;
      bits = 0;
      op = 8'h00;
      for (i = 0; i < 16384; i = i + 1) mem[i] = 8'h00;
   end
   always @(negedge cs_n_i) begin
      bits = 0;
      op = 8'h00;
   end
   always @(posedge cs_n_i) begin
      if (bits >= 8 && (op == 8'h01 || op == 8'h02)) stat_r[1] = 1'b0;
      // Released output never holds a stale bit
      miso_o <= ~miso_o;
   end
   always @(posedge sck_i) if (!cs_n_i) begin
      sh = {sh[30:0], mosi_i};
      bits = bits + 1;
      if (bits == 8) begin
         op = sh[7:0];
         if (op == 8'h06) stat_r[1] = 1'b1;
         if (op == 8'h04) stat_r[1] = 1'b0;
      end
      if (bits == 24) base = sh[13:0];
      if (op == 8'h01 && bits == 16 && stat_r[1] && !(stat_r[7] && !wp_n_i))
         stat_r[7:2] = sh[7:2];
      if (op == 8'h02 && bits >= 32 && bits % 8 == 0) begin
         k = (bits - 32) / 8;
         wa = base + k[13:0];
         if (stat_r[1] && !prot(wa)) mem[wa] = sh[7:0];
      end
   end
   always @(negedge sck_i) if (!cs_n_i) begin
      if (op == 8'h05 && bits >= 8) begin
         miso_o <= stat_r[7 - (bits - 8) % 8];
      end else if ((op == 8'h03 && bits >= 24) || (op == 8'h0b && bits >= 32))
      begin
         k = bits - ((op == 8'h0b) ? 32 : 24);
         ra = base + k[16:3];
         miso_o <= mem[ra][7 - k % 8];
      end else if (op == 8'h9f && bits >= 8) begin
         k = (bits - 8 > 31) ? 31 : bits - 8;
         miso_o <= ID_WORD[31 - k];
      end else begin
         miso_o <= ~miso_o;
      end
   end
endmodule // spi_mem_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the serial memory host controller
`timescale 1ns/100ps
`include "spi_host_regs.vh"
`define CHK(got, exp) begin \
   n_tests = n_tests + 1; \
   if ((got) !== (exp)) begin \
      n_errors = n_errors + 1; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, (got), (exp)); \
   end \
end
module tb_top;
   localparam [31:0] ID_WORD = 32'h1a2b_3c4d; // Arbitrary identity value
   reg         clk = 1'b0;
   reg         rst_n = 1'b0;
   reg  [7:0]  addr = 8'h00;
   reg  [15:0] wdata = 16'h0000;
   reg         we = 1'b0;
   reg         re = 1'b0;
   wire [15:0] rdata;
   wire        cs_n, sck, mosi, miso, wp_n, hold_n;
   reg  [45:0] rows [0:21];
   integer     n_errors = 0;
   integer     n_tests = 0;
   integer     i;
   always #20 clk = ~clk;
   spi_mem_host i_spi_mem_host (
      .CORE_CLK_I (clk), .RST_N_I (rst_n), .ADDR_I (addr),
      .WDATA_I (wdata), .WE_I (we), .RE_I (re), .RDATA_O (rdata),
      .CS_N_O (cs_n), .SCK_O (sck), .MOSI_O (mosi), .MISO_I (miso),
      .WP_N_O (wp_n), .HOLD_N_O (hold_n));
   spi_mem_model #(.ID_WORD (ID_WORD)) i_spi_mem_model (
      .cs_n_i (cs_n), .sck_i (sck), .mosi_i (mosi), .wp_n_i (wp_n),
      .miso_o (miso));
   // ----------------------------------------------------------------
   // Register port tasks
   // ----------------------------------------------------------------
   task wr(input [7:0] a, input [15:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         we <= 1'b1;
         @(posedge clk);
         we <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, output [15:0] d);
      begin
         @(posedge clk);
         addr <= a;
         re <= 1'b1;
         @(posedge clk);
         re <= 1'b0;
         @(negedge clk);
         d = rdata;
      end
   endtask
   task rc(input [7:0] a, input [15:0] e);
      reg [15:0] d;
      begin
         rd(a, d);
         `CHK(d, e)
      end
   endtask
   // Polls are bounded so a stuck frame shows up as a mismatch
   task waitbit(input integer b, input v);
      integer k;
      reg [15:0] s;
      begin
         k = 0;
         rd(`R_STATUS, s);
         while (s[b] !== v && k < 500) begin
            rd(`R_STATUS, s);
            k = k + 1;
         end
         if (k == 500) `CHK(s[b], v)
      end
   endtask
   task xfer(input [7:0] op, input [13:0] a, input [15:0] n, input [7:0] d);
      integer j;
      reg [15:0] r;
      reg wt;
      begin
         wt = (op == `OP_WRITE || op == `OP_STATUS_WRITE);
         wr(`R_OPCODE, {8'h00, op});
         wr(`R_ADDR, {2'b00, a});
         wr(`R_LEN, n);
         if (wt) wr(`R_TXDATA, {8'h00, d});
         wr(`R_CTRL, 16'h0001);
         for (j = 0; j < n; j = j + 1) begin
            if (wt) begin
               waitbit(`STAT_TXFULL_BIT, 1'b0);
               if (j + 1 < n) wr(`R_TXDATA, {8'h00, d + j[7:0] + 8'h01});
            end else begin
               waitbit(`STAT_RXFULL_BIT, 1'b1);
               rd(`R_RXDATA, r);
               `CHK(r[7:0], (op == `OP_STATUS_READ) ? d : d + j[7:0])
            end
         end
         waitbit(`STAT_BUSY_BIT, 1'b0);
      end
   endtask
   task test_done;
      begin
         $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
         if (n_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      #2000000;
      n_errors = n_errors + 1;
      test_done;
   end
   // ----------------------------------------------------------------
   // Table of ordinary transfers, then hand-written cases
   // ----------------------------------------------------------------
   initial begin
      rows[0]  = {8'h05, 14'h0000, 16'd1, 8'h00};
      rows[1]  = {8'h06, 14'h0000, 16'd0, 8'h00};
      rows[2]  = {8'h05, 14'h0000, 16'd1, 8'h02};
      rows[3]  = {8'h04, 14'h0000, 16'd0, 8'h00};
      rows[4]  = {8'h05, 14'h0000, 16'd1, 8'h00};
      rows[5]  = {8'h02, 14'h0010, 16'd2, 8'ha5};
      rows[6]  = {8'h03, 14'h0010, 16'd2, 8'ha5};
      rows[7]  = {8'h0b, 14'h0011, 16'd1, 8'ha6};
      rows[8]  = {8'h05, 14'h0000, 16'd1, 8'h00};
      rows[9]  = {8'h02, 14'h3fff, 16'd2, 8'h5a};
      rows[10] = {8'h03, 14'h3fff, 16'd2, 8'h5a};
      rows[11] = {8'h0b, 14'h3fff, 16'd2, 8'h5a};
      rows[12] = {8'h01, 14'h0000, 16'd1, 8'h8f};
      rows[13] = {8'h05, 14'h0000, 16'd2, 8'h8c};
      rows[14] = {8'h02, 14'h0020, 16'd1, 8'h33};
      rows[15] = {8'h03, 14'h0020, 16'd1, 8'h00};
      rows[16] = {8'h01, 14'h0000, 16'd1, 8'h04};
      rows[17] = {8'h02, 14'h2fff, 16'd1, 8'h11};
      rows[18] = {8'h02, 14'h3000, 16'd1, 8'h22};
      rows[19] = {8'h03, 14'h2fff, 16'd1, 8'h11};
      rows[20] = {8'h03, 14'h3000, 16'd1, 8'h00};
      rows[21] = {8'h9f, 14'h0000, 16'd1, ID_WORD[31:24]};
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK({cs_n, sck, hold_n, wp_n}, 4'b1011)
      rc(`R_OPCODE, 16'h0005);
      rc(`R_ADDR, 16'h0000);
      rc(`R_LEN, 16'h0001);
      rc(`R_WP, 16'h0001);
      rc(`R_STATUS, 16'h0010);
      rc(8'h20, 16'h0000);
      for (i = 0; i < 22; i = i + 1)
         xfer(rows[i][45:38], rows[i][37:24], rows[i][23:8], rows[i][7:0]);
      xfer(8'h01, 14'h0000, 16'd1, 8'h80);
      wr(`R_WP, 16'h0000);
      // Status write with the guard bit set and the pin low must not land
      xfer(8'h01, 14'h0000, 16'd1, 8'h00);
      `CHK(wp_n, 1'b0)
      xfer(8'h05, 14'h0000, 16'd1, 8'h80);
      wr(`R_WP, 16'h0001);
      xfer(8'h01, 14'h0000, 16'd1, 8'h00);
      xfer(8'h05, 14'h0000, 16'd1, 8'h00);
      wr(`R_OPCODE, 16'h0077);
      wr(`R_CTRL, 16'h0001);
      rc(`R_STATUS, 16'h0018);
      wr(`R_STATUS, 16'h0008);
      rc(`R_STATUS, 16'h0010);
      test_done;
   end
endmodule // tb_top
